// *** ish_status_level.sv ***
// ish_status_level: status word, fifo fill counters and sda hold timing of an i2c controller.
// assumes synchronous fifo strobes and fsm idle levels from the controller core on clk.
`timescale 1ns/1ps
module ish_status_level (
  input  wire logic                clk,        // core clock, 20 MHz
  input  wire logic                rst_b,      // async reset, active low
  input  wire logic                wb_cyc_i,   // wishbone cycle
  input  wire logic                wb_stb_i,   // wishbone strobe
  input  wire logic                wb_we_i,    // wishbone write
  input  wire logic [7:0]          wb_adr_i,   // wishbone byte address
  input  wire logic [3:0]          wb_sel_i,   // wishbone byte selects
  input  wire logic [31:0]         wb_dat_i,   // wishbone write data
  output logic      [31:0]         wb_dat_o,   // wishbone read data
  output logic                     wb_ack_o,   // wishbone acknowledge
  output logic                     wb_err_o,   // wishbone error, unmapped
  input  wire ish_pkg::ish_fifo_ev_t fifo_ev,  // fifo strobes
  input  wire ish_pkg::ish_core_ev_t core_ev,  // core fsm and abort levels
  output logic                     core_enable_internal, // enable level to the core
  output ish_pkg::ish_hold_t       hold_cfg    // sda hold timings
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [4:0]  tx_fill_count;     // tx fifo entries
  logic [4:0]  rx_fill_count;     // rx fifo entries
  logic [4:0]  next_tx_fill;      // next tx count
  logic [4:0]  next_rx_fill;      // next rx count
  logic        master_fsm_busy;   // master busy flag
  logic        slave_fsm_busy;    // slave busy flag
  logic [15:0] sda_transmit_hold; // programmed tx hold
  logic [7:0]  sda_receive_hold;  // programmed rx hold
  logic        enable_bit;        // enable_control bit 0
  logic        ack_q;             // ack register

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // an error answer blocks a new take as well, so a held strobe gets a fresh answer every second cycle
  wire req       = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o; // new request
  wire hit_st    = (wb_adr_i == ish_pkg::ISH_OFS_STATUS);
  wire hit_tx    = (wb_adr_i == ish_pkg::ISH_OFS_TX_FILL_COUNT);
  wire hit_rx    = (wb_adr_i == ish_pkg::ISH_OFS_RX_FILL_COUNT);
  wire hit_hold  = (wb_adr_i == ish_pkg::ISH_OFS_HOLD);
  wire hit_en    = (wb_adr_i == ish_pkg::ISH_OFS_ENABLE);
  wire mapped    = hit_st || hit_tx || hit_rx || hit_hold || hit_en;
  wire wr        = req && wb_we_i && mapped;
  // writes to the hold register are dropped while enabled; the bus still acks
  wire hold_wr   = wr && hit_hold && !enable_bit;
  wire en_wr     = wr && hit_en && wb_sel_i[0];

  // ****************************************************************
  // fill level counters
  // ****************************************************************
  // saturating up/down step shared by both counters
  function automatic logic [4:0] lvl_step(input logic [4:0] cur, input logic push,
                                          input logic pop);
    logic [4:0] r;
    r = cur;
    if (push && !pop && cur != ish_pkg::ISH_FIFO_DEPTH) begin
      r = cur + 5'h01;
    end else if (pop && !push && cur != 5'h00) begin
      r = cur - 5'h01;
    end
    return r;
  endfunction

  // clear conditions win over the strobes: a flushed fifo is empty
  wire tx_clear = !enable_bit || core_ev.transmit_abort_event
                  || core_ev.slave_bulk_abort;
  wire rx_clear = !enable_bit || core_ev.abort_cause_any;
  assign next_tx_fill = tx_clear ? 5'h00
                        : lvl_step(tx_fill_count, fifo_ev.tx_push, fifo_ev.tx_pop);
  assign next_rx_fill = rx_clear ? 5'h00
                        : lvl_step(rx_fill_count, fifo_ev.rx_push, fifo_ev.rx_pop);

  // counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_fill_count <= 5'h00;
      rx_fill_count <= 5'h00;
    end else begin
      tx_fill_count <= next_tx_fill;
      rx_fill_count <= next_rx_fill;
    end
  end

  // ****************************************************************
  // activity flags
  // ****************************************************************
  // busy follows the fsm; idle clears it, so once idle while disabled it reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      master_fsm_busy <= 1'b0;
      slave_fsm_busy  <= 1'b0;
    end else begin
      master_fsm_busy <= !core_ev.master_fsm_idle;
      slave_fsm_busy  <= !core_ev.slave_fsm_idle;
    end
  end

  // ****************************************************************
  // status word, fifo flags derived from counters so they can never disagree
  // ****************************************************************
  wire tx_empty_flag    = (tx_fill_count == 5'h00);
  wire tx_notfull_flag  = (tx_fill_count != ish_pkg::ISH_FIFO_DEPTH);
  wire rx_nonempty_flag = (rx_fill_count != 5'h00);
  wire rx_full_flag     = (rx_fill_count == ish_pkg::ISH_FIFO_DEPTH);
  wire activity         = master_fsm_busy || slave_fsm_busy;
  wire [31:0] status_word = {25'h0000000, slave_fsm_busy, master_fsm_busy, rx_full_flag,
                             rx_nonempty_flag, tx_empty_flag, tx_notfull_flag, activity};

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // hold and enable registers, byte lanes honoured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_transmit_hold <= ish_pkg::ISH_TXH_RESET;
      sda_receive_hold  <= ish_pkg::ISH_RXH_RESET;
      enable_bit        <= 1'b0;
    end else begin
      if (hold_wr && wb_sel_i[0]) begin
        sda_transmit_hold[7:0] <= wb_dat_i[7:0];
      end
      if (hold_wr && wb_sel_i[1]) begin
        sda_transmit_hold[15:8] <= wb_dat_i[15:8];
      end
      if (hold_wr && wb_sel_i[2]) begin
        sda_receive_hold <= wb_dat_i[23:16];
      end
      if (en_wr) begin
        enable_bit <= wb_dat_i[ish_pkg::ISH_EN_BIT];
      end
    end
  end

  // effective hold is never below the role minimum
  function automatic logic [15:0] hold_floor(input logic [15:0] v, input logic [15:0] mn);
    return (v > mn) ? v : mn;
  endfunction

  assign core_enable_internal = enable_bit;
  // one packed assignment drives the whole carrier, so it has a single driver
  assign hold_cfg = {hold_floor(sda_transmit_hold, ish_pkg::ISH_TXH_MIN_MST),
                     hold_floor(sda_transmit_hold, ish_pkg::ISH_TXH_MIN_SLV),
                     sda_receive_hold};

  // ****************************************************************
  // read mux and ack
  // ****************************************************************
  // reads are pure selects; no read changes any state
  wire [31:0] rd_mux = hit_st   ? status_word
                     : hit_tx   ? {27'h0000000, tx_fill_count}
                     : hit_rx   ? {27'h0000000, rx_fill_count}
                     : hit_hold ? {8'h00, sda_receive_hold, sda_transmit_hold}
                     : hit_en   ? {31'h0, enable_bit}
                     : 32'h00000000;

  // one wait-free ack cycle after the request, dropped the next cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q    <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q    <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h00000000;
    end
  end
  assign wb_ack_o = ack_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_disabled;
    !enable_bit;
  endsequence
  sequence s_flushed;
    tx_fill_count == 5'h00 && rx_fill_count == 5'h00;
  endsequence

  property p_disable_flush;
    @(posedge clk) disable iff (!rst_b) s_disabled |=> s_flushed;
  endproperty
  a_disable_flush: assert property (p_disable_flush) else $error("fifo levels not flushed");

  property p_disable_flags;
    @(posedge clk) disable iff (!rst_b) s_disabled |=> (tx_empty_flag && tx_notfull_flag
                                                        && !rx_nonempty_flag);
  endproperty
  a_disable_flags: assert property (p_disable_flags) else $error("disable flags wrong");

  property p_hold_locked;
    @(posedge clk) disable iff (!rst_b) enable_bit |=> $stable(sda_transmit_hold)
                                                       && $stable(sda_receive_hold);
  endproperty
  a_hold_locked: assert property (p_hold_locked) else $error("hold changed while enabled");

  property p_tx_push;
    @(posedge clk) disable iff (!rst_b)
      (!tx_clear && fifo_ev.tx_push && !fifo_ev.tx_pop && tx_fill_count < 5'h10)
      |=> tx_fill_count == $past(tx_fill_count) + 5'h01;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("tx level did not step up");

  property p_rx_pop;
    @(posedge clk) disable iff (!rst_b)
      (!rx_clear && fifo_ev.rx_pop && !fifo_ev.rx_push && rx_fill_count != 5'h00)
      |=> rx_fill_count == $past(rx_fill_count) - 5'h01;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx level did not step down");

  property p_abort_tx;
    @(posedge clk) disable iff (!rst_b) core_ev.transmit_abort_event |=> tx_fill_count == 5'h00;
  endproperty
  a_abort_tx: assert property (p_abort_tx) else $error("tx level kept after abort");

  property p_abort_rx;
    @(posedge clk) disable iff (!rst_b) core_ev.abort_cause_any |=> rx_fill_count == 5'h00;
  endproperty
  a_abort_rx: assert property (p_abort_rx) else $error("rx level kept after abort");

  property p_idle_clears;
    @(posedge clk) disable iff (!rst_b)
      (!enable_bit && core_ev.master_fsm_idle && core_ev.slave_fsm_idle) |=> !activity;
  endproperty
  a_idle_clears: assert property (p_idle_clears) else $error("busy kept when idle");

  property p_tx_floor;
    @(posedge clk) disable iff (!rst_b) hold_cfg.sda_transmit_hold_slave >= 16'h0007
      && hold_cfg.sda_transmit_hold_master >= 16'h0001;
  endproperty
  a_tx_floor: assert property (p_tx_floor) else $error("hold below minimum");

  property p_rx_full;
    @(posedge clk) disable iff (!rst_b) rx_full_flag |-> rx_nonempty_flag && rx_fill_count == 5'h10;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full flag wrong");

  // a read only selects; no register may move because of it
  sequence s_read;
    req && !wb_we_i;
  endsequence
  sequence s_cfg_still;
    $stable(sda_transmit_hold) && $stable(sda_receive_hold) && $stable(enable_bit);
  endsequence
  property p_read_clean;
    @(posedge clk) disable iff (!rst_b) s_read |=> s_cfg_still;
  endproperty
  a_read_clean: assert property (p_read_clean) else $error("read moved a register");

  // busy bits trail the fsm idle levels by one edge, enabled or not
  property p_master_busy;
    @(posedge clk) disable iff (!rst_b) master_fsm_busy == !$past(core_ev.master_fsm_idle);
  endproperty
  a_master_busy: assert property (p_master_busy) else $error("master busy wrong");

  property p_slave_busy;
    @(posedge clk) disable iff (!rst_b) slave_fsm_busy == !$past(core_ev.slave_fsm_idle);
  endproperty
  a_slave_busy: assert property (p_slave_busy) else $error("slave busy wrong");

  property p_activity;
    @(posedge clk) disable iff (!rst_b) status_word[ish_pkg::ISH_ST_ACTIVITY]
      == !($past(core_ev.master_fsm_idle) && $past(core_ev.slave_fsm_idle));
  endproperty
  a_activity: assert property (p_activity) else $error("activity bit wrong");

  // the packed word must put each flag where software looks for it
  property p_tx_flags;
    @(posedge clk) disable iff (!rst_b)
      status_word[ish_pkg::ISH_ST_TFE] == (tx_fill_count == 5'h00)
      && status_word[ish_pkg::ISH_ST_TX_NOTFULL_FLAG] == (tx_fill_count != ish_pkg::ISH_FIFO_DEPTH);
  endproperty
  a_tx_flags: assert property (p_tx_flags) else $error("tx flags wrong");

  property p_rx_flags;
    @(posedge clk) disable iff (!rst_b)
      status_word[ish_pkg::ISH_ST_RX_NONEMPTY_FLAG] == (rx_fill_count != 5'h00)
      && status_word[ish_pkg::ISH_ST_RFF] == (rx_fill_count == ish_pkg::ISH_FIFO_DEPTH);
  endproperty
  a_rx_flags: assert property (p_rx_flags) else $error("rx flags wrong");

  // reserved positions read zero whatever is selected
  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b) status_word[31:7] == 25'h0
      && rd_mux[31:24] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  // single steps in the directions the checks above leave out
  property p_tx_pop;
    @(posedge clk) disable iff (!rst_b)
      (!tx_clear && fifo_ev.tx_pop && !fifo_ev.tx_push && tx_fill_count != 5'h00)
      |=> tx_fill_count == $past(tx_fill_count) - 5'h01;
  endproperty
  a_tx_pop: assert property (p_tx_pop) else $error("tx level did not step down");

  property p_rx_push;
    @(posedge clk) disable iff (!rst_b)
      (!rx_clear && fifo_ev.rx_push && !fifo_ev.rx_pop && rx_fill_count != 5'h10)
      |=> rx_fill_count == $past(rx_fill_count) + 5'h01;
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("rx level did not step up");

  property p_bulk_abort;
    @(posedge clk) disable iff (!rst_b) core_ev.slave_bulk_abort |=> tx_fill_count == 5'h00;
  endproperty
  a_bulk_abort: assert property (p_bulk_abort) else $error("tx level kept");

  // a write while disabled lands lane by lane
  sequence s_hold_low;
    hold_wr && wb_sel_i[1:0] == 2'b11;
  endsequence
  property p_hold_tx_write;
    @(posedge clk) disable iff (!rst_b)
      s_hold_low |=> sda_transmit_hold == $past(wb_dat_i[15:0]);
  endproperty
  a_hold_tx_write: assert property (p_hold_tx_write) else $error("tx hold not written");

  property p_hold_rx_write;
    @(posedge clk) disable iff (!rst_b)
      (hold_wr && wb_sel_i[2]) |=> sda_receive_hold == $past(wb_dat_i[23:16]);
  endproperty
  a_hold_rx_write: assert property (p_hold_rx_write) else $error("rx hold not written");

  // the enable bit follows lane 0 of its own register
  property p_enable_write;
    @(posedge clk) disable iff (!rst_b)
      en_wr |=> enable_bit == $past(wb_dat_i[ish_pkg::ISH_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");

  // the first edge out of reset still shows the reset values
  property p_reset_values;
    @(posedge clk) $rose(rst_b) |-> sda_transmit_hold == ish_pkg::ISH_TXH_RESET
      && sda_receive_hold == ish_pkg::ISH_RXH_RESET && status_word[2:1] == 2'b11;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  // each answer is one pulse; a stretched one would be taken twice
  property p_ack_pulse;
    @(posedge clk) disable iff (!rst_b) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  property p_err_pulse;
    @(posedge clk) disable iff (!rst_b) wb_err_o |=> !wb_err_o && !wb_ack_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error held too long");

endmodule

// *** ish_pkg.sv ***
// ish_pkg: shared constants and carrier types for the i2c status, fill level and sda hold block.
// assumes a 32-bit classic wishbone register bus and a core clock of 20 MHz.
package ish_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ISH_OFS_STATUS  = 8'h70; // transfer_status, read only
  localparam logic [7:0] ISH_OFS_TX_FILL_COUNT   = 8'h74; // transmit_fill_level, read only
  localparam logic [7:0] ISH_OFS_RX_FILL_COUNT   = 8'h78; // receive_fill_level, read only
  localparam logic [7:0] ISH_OFS_HOLD    = 8'h7c; // sda_hold_timing, read/write
  localparam logic [7:0] ISH_OFS_ENABLE  = 8'h6c; // enable_control, read/write

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ISH_ST_ACTIVITY = 0;  // overall activity
  localparam int ISH_ST_TX_NOTFULL_FLAG     = 1;  // tx not full
  localparam int ISH_ST_TFE      = 2;  // tx empty
  localparam int ISH_ST_RX_NONEMPTY_FLAG     = 3;  // rx not empty
  localparam int ISH_ST_RFF      = 4;  // rx full
  localparam int ISH_ST_MST      = 5;  // master fsm busy
  localparam int ISH_ST_SLV      = 6;  // slave fsm busy
  localparam int ISH_EN_BIT      = 0;  // enable bit of enable_control
  localparam int ISH_TXH_LSB     = 0;  // transmit hold field low bit
  localparam int ISH_RXH_LSB     = 16; // receive hold field low bit

  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int          ISH_LVL_W      = 5;        // level counter width
  localparam logic [4:0]  ISH_FIFO_DEPTH = 5'h10;    // entries in each fifo
  localparam logic [15:0] ISH_TXH_RESET  = 16'h0001; // transmit hold after reset
  localparam logic [7:0]  ISH_RXH_RESET  = 8'h00;    // receive hold after reset
  localparam logic [15:0] ISH_TXH_MIN_MST = 16'h0001; // least hold as master
  localparam logic [15:0] ISH_TXH_MIN_SLV = 16'h0007; // least hold as slave

  // ****************************************************************
  // carrier types
  // ****************************************************************
  // fifo push/pop strobes from the controller datapath
  typedef struct packed {
    logic tx_push; // word written into tx fifo
    logic tx_pop;  // word taken from tx fifo
    logic rx_push; // word written into rx fifo
    logic rx_pop;  // word taken from rx fifo
  } ish_fifo_ev_t;

  // state machine and abort indications from the core
  typedef struct packed {
    logic master_fsm_idle;     // master fsm in idle
    logic slave_fsm_idle;      // slave fsm in idle
    logic transmit_abort_event; // raw abort flag rising
    logic abort_cause_any;     // any abort cause recorded
    logic slave_bulk_abort;    // slave bulk transmit aborted
  } ish_core_ev_t;

  // hold timings handed to the bus engine
  typedef struct packed {
    logic [15:0] sda_transmit_hold_master; // effective hold as master
    logic [15:0] sda_transmit_hold_slave;  // effective hold as slave
    logic [7:0]  sda_receive_hold;         // rx extension
  } ish_hold_t;

endpackage

// *** ish_core_model.sv ***
// ish_core_model: stand-in for the controller core that feeds the status block.
// assumes the bench calls its tasks; every change lands just after a rising clk edge.
`timescale 1ns/1ps
module ish_core_model (
  input  wire logic             clk,     // core clock
  output ish_pkg::ish_fifo_ev_t fifo_ev, // fifo push and pop strobes
  output ish_pkg::ish_core_ev_t core_ev  // fsm idle levels and abort pulses
);
  // ****************************************************************
  // stimulus
  // ****************************************************************
  // both fsms idle, no strobe, no abort at time zero
  initial begin
    fifo_ev = 4'h0;
    core_ev = 5'h18;
  end

  // n one-cycle strobes; gap+1 idle cycles between them models a slow core
  task automatic strobe(input ish_pkg::ish_fifo_ev_t ev, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) fifo_ev <= ev;
      @(posedge clk) fifo_ev <= 4'h0;
      repeat (gap) @(posedge clk);
    end
  endtask

  // new level set on the core side, held until the next call
  task automatic core_set(input ish_pkg::ish_core_ev_t ev);
    @(posedge clk) core_ev <= ev;
  endtask
endmodule

// *** tb.sv ***
// tb: self-checking bench for ish_status_level over wishbone and the core model.
// assumes a 20 MHz clk, async active-low reset and a one-cycle registered ack.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  logic                  clk     = 1'b0;  // core clock
  logic                  rst_b   = 1'b0;  // reset, active low
  logic                  wb_cyc  = 1'b0;  // bus cycle
  logic                  wb_stb  = 1'b0;  // bus strobe
  logic                  wb_we   = 1'b0;  // bus write
  logic [7:0]            wb_adr  = 8'h00; // bus address
  logic [31:0]           wb_dat  = 32'h0; // bus write data
  logic [3:0]            wb_sel  = 4'hf;  // bus byte lanes
  logic [3:0]            lanes   = 4'hf;  // lanes for the next request
  localparam int         SCL_LOW = 200;   // scl low span in core clocks, a plain figure
  logic [31:0]           wb_dat_o;        // read data
  logic                  wb_ack_o;        // acknowledge
  logic                  wb_err_o;        // error
  logic                  en_int;          // internal enable
  ish_pkg::ish_fifo_ev_t fifo_ev;         // strobes from the core model
  ish_pkg::ish_core_ev_t core_ev;         // levels from the core model
  ish_pkg::ish_hold_t    hold_cfg;        // effective hold timings
  logic [33:0]           notes[$];        // expected {err, check data, data}
  logic [31:0]           seed = 32'h5012ff16; // xorshift state
  int                    errors = 0;      // mismatches
  int                    samples_checked = 0; // comparisons made
  int                    tx = 0;          // expected tx level
  int                    rx = 0;          // expected rx level

  ish_status_level dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .fifo_ev(fifo_ev),
    .core_ev(core_ev), .core_enable_internal(en_int), .hold_cfg(hold_cfg));
  ish_core_model m (.clk(clk), .fifo_ev(fifo_ev), .core_ev(core_ev));

  // ****************************************************************
  // helpers
  // ****************************************************************
  always #25 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // status word the rules demand for given levels and busy bits
  function automatic logic [31:0] stat(int t, int r, logic mb, logic sb);
    return {25'h0, sb, mb, r == 16, r != 0, t == 0, t != 16, mb | sb};
  endfunction

  // one classic cycle; the note is queued before the answer can come
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [33:0] note);
    notes.push_back(note);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= lanes;
    wb_adr <= a;
    wb_dat <= d;
    // no cycle count is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, {2'b01, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 34'h0);
  endtask

  // ****************************************************************
  // result watcher: oldest note against each answer
  // ****************************************************************
  always @(posedge clk) begin
    logic [33:0] note;
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      note = (notes.size() > 0) ? notes.pop_front() : {2'b11, 32'hdead_beef};
      `CHK("bus error", note[33], wb_err_o)
      if (note[32]) `CHK("read data", note[31:0], wb_dat_o)
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog at 20000 cycles, far beyond the few hundred cycles the sequence needs
  initial begin
    #(50 * 20000);
    errors++;
    end_sim();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] v;
    logic [15:0] t;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(ish_pkg::ISH_OFS_STATUS, 32'h6);
    rd(ish_pkg::ISH_OFS_TX_FILL_COUNT, 32'h0);
    rd(ish_pkg::ISH_OFS_RX_FILL_COUNT, 32'h0);
    rd(ish_pkg::ISH_OFS_HOLD, 32'h1);
    wb(1'b0, 8'h00, 32'h0, {2'b10, 32'h0});
    wr(ish_pkg::ISH_OFS_STATUS, 32'hffff_ffff);
    rd(ish_pkg::ISH_OFS_STATUS, 32'h6);
    // hold sweep: 0..8 crosses both minimums, then random values below SCL_LOW - 2
    for (int i = 0; i < 11; i++) begin
      v = rnd();
      if (i < 9) v[15:0] = 16'(i);
      else v[15:0] = v[15:0] % 16'(SCL_LOW - 2);
      t = v[15:0];
      wr(ish_pkg::ISH_OFS_HOLD, v);
      rd(ish_pkg::ISH_OFS_HOLD, v & 32'h00ff_ffff);
      `CHK("hold master", (t > 16'h1) ? t : 16'h1, hold_cfg.sda_transmit_hold_master)
      `CHK("hold slave", (t > 16'h7) ? t : 16'h7, hold_cfg.sda_transmit_hold_slave)
      `CHK("hold rx", v[23:16], hold_cfg.sda_receive_hold)
    end
    wr(ish_pkg::ISH_OFS_ENABLE, 32'h1);
    `CHK("enable", 1'b1, en_int)
    rd(ish_pkg::ISH_OFS_ENABLE, 32'h1);
    wr(ish_pkg::ISH_OFS_HOLD, ~v);
    rd(ish_pkg::ISH_OFS_HOLD, v & 32'h00ff_ffff);
    // each abort kind clears its own level after two pushes into each fifo
    for (int j = 0; j < 3; j++) begin
      m.strobe(ish_pkg::ish_fifo_ev_t'(4'b1010), 2, 0);
      tx += 2;
      rx += 2;
      m.core_set(ish_pkg::ish_core_ev_t'(5'h18 | (5'h04 >> j)));
      m.core_set(ish_pkg::ish_core_ev_t'(5'h18));
      if (j == 1) rx = 0;
      else tx = 0;
      rd(ish_pkg::ISH_OFS_TX_FILL_COUNT, tx);
      rd(ish_pkg::ISH_OFS_RX_FILL_COUNT, rx);
    end
    m.strobe(ish_pkg::ish_fifo_ev_t'(4'b1000), 16, 0);
    m.strobe(ish_pkg::ish_fifo_ev_t'(4'b0010), 16 - rx, 1);
    tx = 16;
    rx = 16;
    rd(ish_pkg::ISH_OFS_TX_FILL_COUNT, 32'h10);
    rd(ish_pkg::ISH_OFS_RX_FILL_COUNT, 32'h10);
    rd(ish_pkg::ISH_OFS_STATUS, stat(tx, rx, 0, 0));
    m.strobe(ish_pkg::ish_fifo_ev_t'(4'b0101), 1, 3);
    rd(ish_pkg::ISH_OFS_STATUS, stat(15, 15, 0, 0));
    // every busy combination of the two fsms
    for (int k = 1; k < 4; k++) begin
      m.core_set(ish_pkg::ish_core_ev_t'({~k[1:0], 3'b000}));
      rd(ish_pkg::ISH_OFS_STATUS, stat(15, 15, k[1], k[0]));
    end
    // disable with both fsms busy and both fifos holding data
    wr(ish_pkg::ISH_OFS_ENABLE, 32'h0);
    `CHK("enable", 1'b0, en_int)
    rd(ish_pkg::ISH_OFS_STATUS, stat(0, 0, 1, 1));
    m.strobe(ish_pkg::ish_fifo_ev_t'(4'b1010), 2, 0);
    rd(ish_pkg::ISH_OFS_TX_FILL_COUNT, 32'h0);
    rd(ish_pkg::ISH_OFS_RX_FILL_COUNT, 32'h0);
    m.core_set(ish_pkg::ish_core_ev_t'(5'h18));
    rd(ish_pkg::ISH_OFS_STATUS, 32'h6);
    // only the receive lane: the transmit hold must keep its value
    lanes = 4'h4;
    wr(ish_pkg::ISH_OFS_HOLD, 32'h00ab_0000);
    rd(ish_pkg::ISH_OFS_HOLD, {8'h00, 8'hab, v[15:0]});
    `CHK("hold rx", 8'hab, hold_cfg.sda_receive_hold)
    end_sim();
  end
endmodule
